// *** core/sbwk_top.sv ***
`timescale 1ns/100ps
// Functional notes
// - standby reset initialises all wake logic
// - host bus ignored while power not good
// - power not good disables IR timeout
// - wake pins keep working without main power
// - enabled wake events pull wake output low
// - tach, LED, key logic use trickle clock
// - fan pins low outputs, inputs without power
// - IR transmit pin low, never wakes
// - IR pins follow port 2 after activate
// - retained GPIO keeps config, basic function
// - reset, A20, density pins never wake
// - standby-only pins input only, reach wake
// - LED pins stay under LED logic
// - runtime registers kept across main loss
// - trickle-absent bit resets 0, selects source
module sbwk_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power and resets from pins
    input wire logic host_power_good,
    input wire logic vcc_por_n,
    input wire logic hard_reset_n,
    input wire logic trickle_clock_in,
    // wake source pins; ir_receive only feeds pin status
    input wire logic ring_ind_a_n,
    input wire logic ring_ind_b_n,
    input wire logic kbd_data,
    input wire logic mouse_data,
    input wire logic ir_receive,
    input wire logic spec_key_match,
    input wire logic fan_tach_a,
    input wire logic fan_tach_b,
    input wire logic usb_port_event,
    // gpio pins without standby input path
    input wire logic kbd_reset_gpio,
    input wire logic gate_a20_gpio,
    input wire logic drive_density_gpio,
    // retained gpio pin
    input wire logic retained_gpio_in,
    input wire logic retained_alt_out,
    output logic retained_gpio_out,
    output logic retained_gpio_oe,
    // fan control pins
    input wire logic fan_ctl_pin_a_in,
    input wire logic fan_ctl_pin_b_in,
    output logic fan_ctl_pin_a_out,
    output logic fan_ctl_pin_b_out,
    output logic fan_ctl_oe,
    // serial port 2 and IR
    input wire logic sp2_txd,
    output logic ir_tx_pin_a,
    output logic ir_tx_pin_b,
    output logic ir_hd_timeout_en,
    // led pins
    output logic led_pin_a,
    output logic led_pin_b,
    // wake and interrupt
    output logic wake_request_out_n_out,
    output logic wake_request_out_n_oe,
    output logic irq
);

    logic [1:0] rst_pipe_r;
    logic rst_n;
    sbwk_pkg::sbwk_pins_s pins_raw;
    sbwk_pkg::sbwk_pins_s pins_s;
    sbwk_pkg::sbwk_pins_s pins_q_r;
    logic prev_vld_r;
    logic pg_s;
    logic main_rst;
    sbwk_pkg::sbwk_pwr_e pwr_r;
    sbwk_pkg::sbwk_pwr_e pwr_nxt;
    logic tick;
    logic blink_slow;
    logic blink_fast;
    logic [2:0] slow_q_r;
    sbwk_pkg::sbwk_wake_s wake_ev;
    logic [8:0] wake_sts_r;
    logic [8:0] wake_en_r;
    logic [8:0] irq_mask_r;
    logic [4:0] ctrl_r;
    sbwk_pkg::sbwk_gpio_cfg_s gpio_cfg_r;
    logic [3:0] led_ctrl_r;
    logic setup;
    logic access;
    logic wr;
    logic rd_clr;
    logic [31:0] rd_data;
    logic gpio_alt_eff;
    logic gpio_drv;
    logic [1:0] led_mode_a;
    logic [1:0] led_mode_b;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == sbwk_pkg::WAKE_STS_OFS) || (a == sbwk_pkg::WAKE_EN_OFS) ||
                  (a == sbwk_pkg::IRQ_MASK_OFS) || (a == sbwk_pkg::CTRL_OFS) ||
                  (a == sbwk_pkg::GPIO_CFG_OFS) || (a == sbwk_pkg::LED_CTRL_OFS) ||
                  (a == sbwk_pkg::PIN_STS_OFS);
    endfunction : addr_ok

    function automatic logic led_level(input logic [1:0] mode, input logic slow, input logic fast);
        case (mode)
            sbwk_pkg::LED_ON: led_level = 1'b1;
            sbwk_pkg::LED_SLOW: led_level = slow;
            sbwk_pkg::LED_FAST: led_level = fast;
            default: led_level = 1'b0;
        endcase
    endfunction : led_level

    // standby power-on reset, released through two flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    assign pins_raw = '{ring_a_n: ring_ind_a_n, ring_b_n: ring_ind_b_n, kbd: kbd_data, mouse: mouse_data,
                        ir_rx: ir_receive, spec_key: spec_key_match, tach_a: fan_tach_a, tach_b: fan_tach_b,
                        usb: usb_port_event, kbd_rst: kbd_reset_gpio, gate_a20: gate_a20_gpio,
                        drv_den: drive_density_gpio, gpio: retained_gpio_in, fan_a: fan_ctl_pin_a_in,
                        fan_b: fan_ctl_pin_b_in, trickle: trickle_clock_in, pg: host_power_good,
                        vcc_por_n: vcc_por_n, hard_rst_n: hard_reset_n};

    sbwk_sync #(.W($bits(sbwk_pkg::sbwk_pins_s))) u_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .d(pins_raw),
        .q(pins_s)
    );

    assign pg_s = pins_s.pg;
    assign main_rst = !pins_s.vcc_por_n || !pins_s.hard_rst_n;

    sbwk_tick u_tick (
        .clk(core_clk),
        .rst_n(rst_n),
        .trickle_s(pins_s.trickle),
        .use_internal(ctrl_r[sbwk_pkg::CTRL_CLK32_ABSENT]),
        .tick(tick),
        .blink_slow(blink_slow),
        .blink_fast(blink_fast)
    );

    // power state: main supply entry always passes through main reset
    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            sbwk_pkg::PWR_STBY: if (pg_s) pwr_nxt = sbwk_pkg::PWR_MRST;
            sbwk_pkg::PWR_MRST: begin
                if (!pg_s) pwr_nxt = sbwk_pkg::PWR_STBY;
                else if (!main_rst) pwr_nxt = sbwk_pkg::PWR_ON;
            end
            sbwk_pkg::PWR_ON: begin
                if (!pg_s) pwr_nxt = sbwk_pkg::PWR_STBY;
                else if (main_rst) pwr_nxt = sbwk_pkg::PWR_MRST;
            end
            default: pwr_nxt = sbwk_pkg::PWR_STBY;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_r <= sbwk_pkg::PWR_STBY;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // edge detection on synchronised pins; first cycle after reset has no history
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_q_r <= '0;
            prev_vld_r <= 1'b0;
        end else begin
            pins_q_r <= pins_s;
            prev_vld_r <= 1'b1;
        end
    end

    // tach and key inputs sampled only on the trickle tick
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_q_r <= 3'b000;
        end else if (tick) begin
            slow_q_r <= {pins_s.spec_key, pins_s.tach_b, pins_s.tach_a};
        end
    end

    // kbd_rst, gate_a20 and drv_den have no path into the events below
    always_comb begin
        wake_ev.ring_a = prev_vld_r && pins_q_r.ring_a_n && !pins_s.ring_a_n;
        wake_ev.ring_b = prev_vld_r && pins_q_r.ring_b_n && !pins_s.ring_b_n;
        wake_ev.kbd = prev_vld_r && pins_q_r.kbd && !pins_s.kbd;
        wake_ev.mouse = prev_vld_r && pins_q_r.mouse && !pins_s.mouse;
        wake_ev.spec_key = tick && pins_s.spec_key && !slow_q_r[2];
        wake_ev.tach_a = tick && pins_s.tach_a && !slow_q_r[0];
        wake_ev.tach_b = tick && pins_s.tach_b && !slow_q_r[1];
        wake_ev.gpio = prev_vld_r && !gpio_cfg_r.dir_out &&
                       ((pins_s.gpio ^ gpio_cfg_r.inv) && !(pins_q_r.gpio ^ gpio_cfg_r.inv));
        wake_ev.usb = prev_vld_r && pins_s.usb && !pins_q_r.usb;
    end

    // apb: zero-wait answer, decode state fixed at the setup edge
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr = access && pwrite && !pslverr;
    assign rd_clr = access && !pwrite && !pslverr && (paddr == sbwk_pkg::WAKE_STS_OFS);

    always_comb begin
        rd_data = '0;
        case (paddr)
            sbwk_pkg::WAKE_STS_OFS: rd_data[sbwk_pkg::WAKE_W-1:0] = wake_sts_r;
            sbwk_pkg::WAKE_EN_OFS: rd_data[sbwk_pkg::WAKE_W-1:0] = wake_en_r;
            sbwk_pkg::IRQ_MASK_OFS: rd_data[sbwk_pkg::WAKE_W-1:0] = irq_mask_r;
            sbwk_pkg::CTRL_OFS: rd_data[sbwk_pkg::CTRL_W-1:0] = ctrl_r;
            sbwk_pkg::GPIO_CFG_OFS: rd_data[sbwk_pkg::GPIO_CFG_W-1:0] = gpio_cfg_r;
            sbwk_pkg::LED_CTRL_OFS: rd_data[sbwk_pkg::LED_W-1:0] = led_ctrl_r;
            sbwk_pkg::PIN_STS_OFS: rd_data[sbwk_pkg::PIN_STS_W-1:0] = {pwr_r, pg_s, pins_s.fan_b, pins_s.fan_a,
                pins_s.gpio, pins_s.drv_den, pins_s.gate_a20, pins_s.kbd_rst, pins_s.ir_rx};
            default: rd_data = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= !pg_s || !addr_ok(paddr);
                prdata <= (pg_s && !pwrite) ? rd_data : 32'h0000_0000;
            end
        end
    end

    // runtime registers: only the standby reset clears them
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_en_r <= sbwk_pkg::WAKE_RST;
            irq_mask_r <= sbwk_pkg::WAKE_RST;
            gpio_cfg_r <= sbwk_pkg::GPIO_CFG_RST;
            led_ctrl_r <= sbwk_pkg::LED_RST;
        end else if (wr) begin
            if (paddr == sbwk_pkg::WAKE_EN_OFS) wake_en_r <= pwdata[sbwk_pkg::WAKE_W-1:0];
            if (paddr == sbwk_pkg::IRQ_MASK_OFS) irq_mask_r <= pwdata[sbwk_pkg::WAKE_W-1:0];
            if (paddr == sbwk_pkg::GPIO_CFG_OFS) gpio_cfg_r <= pwdata[sbwk_pkg::GPIO_CFG_W-1:0];
            if (paddr == sbwk_pkg::LED_CTRL_OFS) led_ctrl_r <= pwdata[sbwk_pkg::LED_W-1:0];
        end
    end

    // port 2 activate and fan levels are cleared by main reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= sbwk_pkg::CTRL_RST;
        end else if (pwr_r == sbwk_pkg::PWR_MRST) begin
            ctrl_r <= ctrl_r & ~sbwk_pkg::CTRL_MAIN_CLR;
        end else if (wr && paddr == sbwk_pkg::CTRL_OFS) begin
            ctrl_r <= pwdata[sbwk_pkg::CTRL_W-1:0];
        end
    end

    // sticky status; a new event beats the read clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_sts_r <= sbwk_pkg::WAKE_RST;
        end else begin
            wake_sts_r <= (wake_sts_r & ~{sbwk_pkg::WAKE_W{rd_clr}}) | wake_ev;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_request_out_n_oe <= 1'b0;
            wake_request_out_n_out <= 1'b0;
            irq <= 1'b0;
        end else begin
            wake_request_out_n_oe <= |(wake_sts_r & wake_en_r);
            wake_request_out_n_out <= 1'b0;
            irq <= |(wake_sts_r & irq_mask_r);
        end
    end

    // fan pins: driven only with main power, otherwise plain inputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fan_ctl_oe <= 1'b0;
            fan_ctl_pin_a_out <= 1'b0;
            fan_ctl_pin_b_out <= 1'b0;
        end else begin
            fan_ctl_oe <= (pwr_r != sbwk_pkg::PWR_STBY);
            fan_ctl_pin_a_out <= (pwr_r == sbwk_pkg::PWR_ON) && ctrl_r[sbwk_pkg::CTRL_FAN_A];
            fan_ctl_pin_b_out <= (pwr_r == sbwk_pkg::PWR_ON) && ctrl_r[sbwk_pkg::CTRL_FAN_B];
        end
    end

    // both IR transmit pins are always driven; low unless port 2 is live
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_tx_pin_a <= 1'b0;
            ir_tx_pin_b <= 1'b0;
            ir_hd_timeout_en <= 1'b0;
        end else begin
            ir_tx_pin_a <= (pwr_r == sbwk_pkg::PWR_ON) && ctrl_r[sbwk_pkg::CTRL_SP2_ACT] && sp2_txd;
            ir_tx_pin_b <= (pwr_r == sbwk_pkg::PWR_ON) && ctrl_r[sbwk_pkg::CTRL_SP2_ACT] && sp2_txd;
            ir_hd_timeout_en <= pg_s && ctrl_r[sbwk_pkg::CTRL_IR_HDTO];
        end
    end

    // retained gpio: alternate function only with main power
    assign gpio_alt_eff = gpio_cfg_r.alt && (pwr_r == sbwk_pkg::PWR_ON);
    assign gpio_drv = gpio_alt_eff ? retained_alt_out : (gpio_cfg_r.out_val ^ gpio_cfg_r.inv);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            retained_gpio_oe <= 1'b0;
            retained_gpio_out <= 1'b0;
        end else begin
            retained_gpio_oe <= (pwr_r != sbwk_pkg::PWR_STBY) && gpio_cfg_r.dir_out &&
                                (!gpio_cfg_r.od || !gpio_drv);
            retained_gpio_out <= gpio_cfg_r.od ? 1'b0 : gpio_drv;
        end
    end

    // leds are driven in every power state
    assign led_mode_a = led_ctrl_r[sbwk_pkg::LED_A_LSB +: 2];
    assign led_mode_b = led_ctrl_r[sbwk_pkg::LED_B_LSB +: 2];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            led_pin_a <= 1'b0;
            led_pin_b <= 1'b0;
        end else begin
            led_pin_a <= led_level(led_mode_a, blink_slow, blink_fast);
            led_pin_b <= led_level(led_mode_b, blink_slow, blink_fast);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sync_depth_a: assert property (##3 1 |-> pg_s == $past(host_power_good, 2))
        else $error("power good not delayed by two flops");
    bus_gate_a: assert property (setup && !pg_s |=> pslverr && pready && prdata == 32'h0000_0000)
        else $error("bus access decoded without power good");
    no_write_a: assert property (access && pslverr |=> $stable(ctrl_r) && $stable(wake_en_r))
        else $error("refused write changed a register");
    hdto_off_a: assert property (!pg_s |=> !ir_hd_timeout_en)
        else $error("IR timeout enabled without power good");
    wake_drive_a: assert property (|(wake_ev & wake_en_r) |-> ##[1:2] wake_request_out_n_oe)
        else $error("enabled wake event did not drive wake output");
    fan_release_a: assert property (pwr_r == sbwk_pkg::PWR_STBY |=> !fan_ctl_oe)
        else $error("fan pin driven without main power");
    fan_low_a: assert property (pwr_r == sbwk_pkg::PWR_MRST |=> fan_ctl_oe && !fan_ctl_pin_a_out && !fan_ctl_pin_b_out)
        else $error("fan pin not low output in main reset");
    irtx_low_a: assert property (pwr_r != sbwk_pkg::PWR_ON |=> !ir_tx_pin_a && !ir_tx_pin_b)
        else $error("IR transmit not low");
    gpio_input_a: assert property (pwr_r == sbwk_pkg::PWR_STBY |=> !retained_gpio_oe)
        else $error("retained gpio driven under standby");
    led_on_a: assert property (led_mode_a == sbwk_pkg::LED_ON [*2] |-> led_pin_a)
        else $error("LED not on in steady on mode");
    clr_set_a: assert property (rd_clr && wake_ev.kbd |=> wake_sts_r[2])
        else $error("event lost against read clear");

    wake_cov_c: cover property (!pg_s ##1 $rose(wake_request_out_n_oe));
    write_cov_c: cover property (wr && paddr == sbwk_pkg::CTRL_OFS);
    pg_fall_c: cover property ($fell(pg_s));
    blink_cov_c: cover property ($rose(led_pin_b));

endmodule : sbwk_top

// *** pkg/sbwk_pkg.sv ***
package sbwk_pkg;

    // clock rates and derived counts
    localparam int unsigned CORE_HZ = 20_000_000;
    localparam int unsigned TRICKLE_HZ = 32_768;
    localparam int unsigned TRICKLE_DIV = CORE_HZ / TRICKLE_HZ;
    localparam int DIV_W = 10;
    localparam logic [9:0] TRICKLE_DIV_LAST = 10'(TRICKLE_DIV - 1);
    localparam int BLINK_W = 15;
    localparam int BLINK_SLOW_BIT = 14;
    localparam int BLINK_FAST_BIT = 12;

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] WAKE_STS_OFS = 8'h00;
    localparam logic [7:0] WAKE_EN_OFS = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
    localparam logic [7:0] CTRL_OFS = 8'h0C;
    localparam logic [7:0] GPIO_CFG_OFS = 8'h10;
    localparam logic [7:0] LED_CTRL_OFS = 8'h14;
    localparam logic [7:0] PIN_STS_OFS = 8'h18;

    // control register fields
    localparam int CTRL_W = 5;
    localparam int CTRL_SP2_ACT = 0;
    localparam int CTRL_CLK32_ABSENT = 1;
    localparam int CTRL_FAN_A = 2;
    localparam int CTRL_FAN_B = 3;
    localparam int CTRL_IR_HDTO = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [4:0] CTRL_MAIN_CLR = 5'h0D;

    // led control fields, two bits per pin
    localparam int LED_W = 4;
    localparam int LED_A_LSB = 0;
    localparam int LED_B_LSB = 2;
    localparam logic [3:0] LED_RST = 4'h0;
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_ON = 2'h1;
    localparam logic [1:0] LED_SLOW = 2'h2;
    localparam logic [1:0] LED_FAST = 2'h3;

    // wake status, enable and mask share this layout
    localparam int WAKE_W = 9;
    localparam logic [8:0] WAKE_RST = 9'h000;
    typedef struct packed {
        logic usb;
        logic gpio;
        logic tach_b;
        logic tach_a;
        logic spec_key;
        logic mouse;
        logic kbd;
        logic ring_b;
        logic ring_a;
    } sbwk_wake_s;

    // retained gpio configuration
    localparam int GPIO_CFG_W = 5;
    localparam logic [4:0] GPIO_CFG_RST = 5'h00;
    typedef struct packed {
        logic alt;
        logic od;
        logic inv;
        logic dir_out;
        logic out_val;
    } sbwk_gpio_cfg_s;

    // pin status readback width
    localparam int PIN_STS_W = 11;

    // all asynchronous pin inputs, synchronised together
    typedef struct packed {
        logic ring_a_n;
        logic ring_b_n;
        logic kbd;
        logic mouse;
        logic ir_rx;
        logic spec_key;
        logic tach_a;
        logic tach_b;
        logic usb;
        logic kbd_rst;
        logic gate_a20;
        logic drv_den;
        logic gpio;
        logic fan_a;
        logic fan_b;
        logic trickle;
        logic pg;
        logic vcc_por_n;
        logic hard_rst_n;
    } sbwk_pins_s;

    typedef enum logic [2:0] {
        PWR_STBY = 3'b001,
        PWR_MRST = 3'b010,
        PWR_ON = 3'b100
    } sbwk_pwr_e;

endpackage : sbwk_pkg

// *** core/sbwk_sync.sv ***
`timescale 1ns/100ps
module sbwk_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : sbwk_sync

// *** core/sbwk_tick.sv ***
`timescale 1ns/100ps
module sbwk_tick (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // trickle clock level, already synchronised
    input wire logic trickle_s,
    input wire logic use_internal,
    // enables and blink levels
    output logic tick,
    output logic blink_slow,
    output logic blink_fast
);

    logic trickle_q_r;
    logic [sbwk_pkg::DIV_W-1:0] div_r;
    logic [sbwk_pkg::BLINK_W-1:0] blink_r;
    logic int_tick;

    assign int_tick = (div_r == sbwk_pkg::TRICKLE_DIV_LAST);

    // fallback divider only approximates 32.768 kHz; rounding down keeps it slightly fast
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (int_tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trickle_q_r <= 1'b0;
            tick <= 1'b0;
        end else begin
            trickle_q_r <= trickle_s;
            tick <= use_internal ? int_tick : (trickle_s && !trickle_q_r);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_r <= '0;
        end else if (tick) begin
            blink_r <= blink_r + 1'b1;
        end
    end

    assign blink_slow = blink_r[sbwk_pkg::BLINK_SLOW_BIT];
    assign blink_fast = blink_r[sbwk_pkg::BLINK_FAST_BIT];

endmodule : sbwk_tick

// *** verif/sbwk_pm_model.sv ***
`timescale 1ns/100ps
module sbwk_pm_model (
    // wake pin from device
    input wire logic wake_oe,
    // level seen by the chipset
    output logic wake_line_n
);
    // board pull-up: the line is high unless the device sinks it
    assign wake_line_n = wake_oe ? 1'b0 : 1'b1;
endmodule : sbwk_pm_model

// *** verif/sbwk_tb_top.sv ***
`timescale 1ns/100ps
module sbwk_tb_top;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic r;} sbwk_row_s;
    logic core_clk = '0, arst_n = '0, psel = '0, penable = '0, pwrite = '0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, wake_line_n, irq;
    logic host_power_good = '0, vcc_por_n = '0, hard_reset_n = '1, trickle_clock_in = '0, sp2_txd = '0;
    logic ring_ind_a_n = '1, ring_ind_b_n = '1, kbd_data = '1, mouse_data = '1, usb_port_event = '0;
    logic kbd_reset_gpio = '0, gate_a20_gpio = '0, drive_density_gpio = '0, ir_receive = '0;
    logic spec_key_match = '0, fan_tach_a = '0, fan_tach_b = '0, retained_alt_out = '0;
    logic retained_gpio_in, retained_gpio_out, retained_gpio_oe, fan_ctl_pin_a_in, fan_ctl_pin_b_in;
    logic fan_ctl_pin_a_out, fan_ctl_pin_b_out, fan_ctl_oe, ir_tx_pin_a, ir_tx_pin_b, ir_hd_timeout_en;
    logic led_pin_a, led_pin_b, wake_request_out_n_out, wake_request_out_n_oe;
    int miscompares = 0, n_compared = 0, cyc = 0;
    sbwk_row_s rows[6];
    sbwk_top dut (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .host_power_good, .vcc_por_n, .hard_reset_n, .trickle_clock_in, .ring_ind_a_n, .ring_ind_b_n,
        .kbd_data, .mouse_data, .ir_receive, .spec_key_match, .fan_tach_a, .fan_tach_b, .usb_port_event,
        .kbd_reset_gpio, .gate_a20_gpio, .drive_density_gpio, .retained_gpio_in, .retained_alt_out,
        .retained_gpio_out, .retained_gpio_oe, .fan_ctl_pin_a_in, .fan_ctl_pin_b_in, .fan_ctl_pin_a_out,
        .fan_ctl_pin_b_out, .fan_ctl_oe, .sp2_txd, .ir_tx_pin_a, .ir_tx_pin_b, .ir_hd_timeout_en,
        .led_pin_a, .led_pin_b, .wake_request_out_n_out, .wake_request_out_n_oe, .irq);
    sbwk_pm_model pm (.wake_oe(wake_request_out_n_oe), .wake_line_n(wake_line_n));
    // pins read back what is driven, pulled low when released
    assign retained_gpio_in = retained_gpio_oe ? retained_gpio_out : 1'b0;
    assign fan_ctl_pin_a_in = fan_ctl_oe ? fan_ctl_pin_a_out : 1'b0;
    assign fan_ctl_pin_b_in = fan_ctl_oe ? fan_ctl_pin_b_out : 1'b0;
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        forever #15259 trickle_clock_in = ~trickle_clock_in;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            finish_test();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task chkp(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask : chkp
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= '1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= '1;
        @(posedge core_clk);
        // pready ends this wait; if pready never comes, only the bench timeout ends it
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= '0;
        penable <= '0;
    endtask : apb
    task done(input string s);
        $display("test %s done", s);
    endtask : done
    task finish_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        rows[0] = '{sbwk_pkg::WAKE_EN_OFS, 32'h1FF, 32'h1FF, 1'b0};
        rows[1] = '{sbwk_pkg::IRQ_MASK_OFS, 32'h1, 32'h1, 1'b0};
        rows[2] = '{sbwk_pkg::GPIO_CFG_OFS, 32'hE, 32'hE, 1'b0};
        rows[3] = '{sbwk_pkg::LED_CTRL_OFS, 32'h5, 32'h5, 1'b0};
        rows[4] = '{sbwk_pkg::CTRL_OFS, 32'h10, 32'h10, 1'b0};
        rows[5] = '{8'h1C, 32'hFF, 32'h0, 1'b1};
        repeat (16) @(posedge core_clk);
        arst_n <= '1;
        repeat (6) @(posedge core_clk);
        chkp(wake_request_out_n_oe, 1'b0);
        chkp(ir_tx_pin_b, 1'b0);
        apb(1'b0, sbwk_pkg::WAKE_EN_OFS, 32'h0);
        chkp(err, 1'b1);
        chkp(ir_hd_timeout_en, 1'b0);
        done("standby");
        host_power_good <= '1;
        repeat (8) @(posedge core_clk);
        chkp(fan_ctl_oe, 1'b1);
        chkp(fan_ctl_pin_a_out, 1'b0);
        apb(1'b0, sbwk_pkg::PIN_STS_OFS, 32'h0);
        chk(rd, 32'h280);
        vcc_por_n <= '1;
        repeat (8) @(posedge core_clk);
        apb(1'b0, sbwk_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        done("main reset");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].e);
            chkp(err, rows[i].r);
        end
        sp2_txd <= '1;
        repeat (4) @(posedge core_clk);
        chkp(led_pin_a, 1'b1);
        chkp(ir_tx_pin_a, 1'b0);
        apb(1'b1, sbwk_pkg::CTRL_OFS, 32'h1D);
        repeat (4) @(posedge core_clk);
        chkp(fan_ctl_pin_b_out, 1'b1);
        chkp(retained_gpio_oe, 1'b0);
        chkp(ir_tx_pin_a, 1'b1);
        chkp(ir_tx_pin_b, 1'b1);
        chkp(ir_hd_timeout_en, 1'b1);
        done("registers");
        ring_ind_a_n <= '0;
        repeat (10) @(posedge core_clk);
        chkp(wake_line_n, 1'b0);
        chkp(irq, 1'b1);
        apb(1'b0, sbwk_pkg::WAKE_STS_OFS, 32'h0);
        chk(rd, 32'h1);
        repeat (4) @(posedge core_clk);
        chkp(irq, 1'b0);
        kbd_reset_gpio <= '1;
        gate_a20_gpio <= '1;
        drive_density_gpio <= '1;
        repeat (10) @(posedge core_clk);
        chkp(wake_line_n, 1'b1);
        apb(1'b0, sbwk_pkg::WAKE_STS_OFS, 32'h0);
        chk(rd, 32'h0);
        done("wake");
        apb(1'b1, sbwk_pkg::WAKE_EN_OFS, 32'h19F);
        host_power_good <= '0;
        repeat (10) @(posedge core_clk);
        chkp(ir_tx_pin_a, 1'b0);
        chkp(fan_ctl_oe, 1'b0);
        chkp(ir_hd_timeout_en, 1'b0);
        chkp(led_pin_b, 1'b1);
        apb(1'b0, sbwk_pkg::WAKE_EN_OFS, 32'h0);
        chkp(err, 1'b1);
        kbd_data <= '0;
        mouse_data <= '0;
        ring_ind_b_n <= '0;
        usb_port_event <= '1;
        repeat (10) @(posedge core_clk);
        chkp(wake_line_n, 1'b0);
        host_power_good <= '1;
        repeat (10) @(posedge core_clk);
        apb(1'b0, sbwk_pkg::WAKE_EN_OFS, 32'h0);
        chk(rd, 32'h19F);
        apb(1'b0, sbwk_pkg::GPIO_CFG_OFS, 32'h0);
        chk(rd, 32'hE);
        apb(1'b0, sbwk_pkg::WAKE_STS_OFS, 32'h0);
        chk(rd, 32'h10E);
        chkp(ir_tx_pin_a, 1'b0);
        apb(1'b0, sbwk_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h10);
        done("power loss");
        apb(1'b1, sbwk_pkg::CTRL_OFS, 32'h18);
        repeat (4) @(posedge core_clk);
        chkp(fan_ctl_pin_b_out, 1'b1);
        hard_reset_n <= '0;
        repeat (6) @(posedge core_clk);
        chkp(fan_ctl_oe, 1'b1);
        chkp(fan_ctl_pin_b_out, 1'b0);
        hard_reset_n <= '1;
        repeat (6) @(posedge core_clk);
        apb(1'b0, sbwk_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h10);
        done("hard reset");
        finish_test();
    end
endmodule : sbwk_tb_top
